// *** verilog/fic_map.svh ***
/*
 Offsets, field positions, reset values and timing counts for the frame
 index and configure flag register slice.
 Assumes a 10 MHz controller clock and a 32-bit word register port.
*/
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH

`define FIC_OFF_INTR_EN 8'h28
`define FIC_OFF_UF_INDEX 8'h2c
`define FIC_OFF_CONFIG 8'h60
`define FIC_UF_INDEX_W 14
`define FIC_UF_INDEX_RST 14'h0000
`define FIC_LIST_LSB 3
`define FIC_CFG_BIT 0
`define FIC_CFG_RST 1'b0
`define FIC_CLK_NS 100
`define FIC_UFRAME_NS 125000
`define FIC_UFRAME_CYC (`FIC_UFRAME_NS / `FIC_CLK_NS)
`define FIC_NUM_PORTS 3

`endif

// *** verilog/fic_pkg.sv ***
/*
 Types shared by the frame index and configure flag register slice.
 Assumes fic_map.svh is on the include path.
*/
`include "fic_map.svh"

package fic_pkg;

	typedef logic [`FIC_UF_INDEX_W-1:0] fic_index_t;

	// Frame list size selector: 1024, 512 or 256 entries
	typedef enum logic [1:0] {
		FIC_FLS_1024,
		FIC_FLS_512,
		FIC_FLS_256,
		FIC_FLS_RSVD
	} fic_fls_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} fic_bus_req_s;

	typedef struct packed {
		fic_index_t frame_number;
		logic [9:0] list_index;
		logic rollover;
	} fic_frame_s;

endpackage : fic_pkg

// *** verilog/fic_uframe_timer.sv ***
/*
 Microframe timer: pulses once per 125 us while the controller runs.
 Assumes the 10 MHz controller clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "fic_map.svh"

module fic_uframe_timer
	import fic_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic restart,
	// Event
	output logic tick
);

	localparam int CYC = `FIC_UFRAME_CYC;
	logic [10:0] count;
	logic [10:0] next_count;
	logic next_tick;

	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!run || restart) begin
			next_count = 11'h000;
		end else if (count == 11'(CYC - 1)) begin
			next_count = 11'h000;
			next_tick = 1'b1;
		end else begin
			next_count = count + 11'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			count <= 11'h000;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

	property p_tick_period;
		@(posedge ref_clk) disable iff (sys_rst)
		tick |-> $past(count) == 11'(CYC - 1);
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("microframe tick off period");

endmodule : fic_uframe_timer

// *** verilog/fic_regs.sv ***
/*
 Frame index and configure flag register slice of the host controller.
 Assumes a word-wide register port with one-cycle read and write strobes;
 run_stop and frame_list_size come from the command register outside.
*/
// Function
// - Interrupt-enable register at 0x28 is all reserved and reads zero.
// - Frame index advances once per 125 us microframe.
// - Frame index bits from 3 up select the periodic list entry.
// - A frame index write changes later start-of-frame numbers.
// - Bits 13:0 serve as frame number, bits 12:3 as list index.
// - Frame index at 0x2c, 14-bit read/write, resets to zero.
// - Configure flag at 0x60 bit 0, read/write, resets to zero.
// - Configure flag drives default port routing.
// - Run/stop 1 runs, 0 stops; schedule runs only when set.
// - Rollover flag pulses when the list index wraps to zero.
// - Port owner clears on flag rise, held at one while flag is zero.
`timescale 1ns/1ps
`include "fic_map.svh"

module fic_regs
	import fic_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire fic_bus_req_s bus_req,
	input wire logic [3:0] bus_be,
	output logic [31:0] bus_rdata,
	output logic bus_rvalid,
	// Command register fields
	input wire logic run_stop,
	input wire logic [1:0] frame_list_size,
	// Port owner write requests from port registers
	input wire logic [`FIC_NUM_PORTS-1:0] port_owner_wr,
	input wire logic [`FIC_NUM_PORTS-1:0] port_owner_wdata,
	// Frame outputs
	output fic_frame_s frame,
	output logic frame_list_rollover,
	output logic schedule_run,
	output logic configured_bit,
	output logic [`FIC_NUM_PORTS-1:0] port_owner
);

	fic_index_t microframe_index;
	fic_index_t next_index;
	logic next_cfg;
	logic next_rollover;
	logic [9:0] next_list;
	logic [31:0] next_rdata;
	logic [`FIC_NUM_PORTS-1:0] next_owner;
	logic tick;
	logic idx_wr;
	logic cfg_wr;
	logic [9:0] list_mask;

	fic_uframe_timer u_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.run(run_stop),
		.restart(idx_wr),
		.tick(tick)
	);

	assign idx_wr = bus_req.wr && bus_req.addr == `FIC_OFF_UF_INDEX
		&& bus_be == 4'hf;
	assign cfg_wr = bus_req.wr && bus_req.addr == `FIC_OFF_CONFIG
		&& bus_be[0];

	always_comb begin
		unique case (fic_fls_e'(frame_list_size))
			FIC_FLS_512: list_mask = 10'h1ff;
			FIC_FLS_256: list_mask = 10'h0ff;
			default: list_mask = 10'h3ff;
		endcase
	end

	// Frame index and rollover
	always_comb begin
		next_index = microframe_index;
		next_rollover = 1'b0;
		if (idx_wr) begin
			next_index = bus_req.wdata[`FIC_UF_INDEX_W-1:0];
		end else if (tick) begin
			next_index = microframe_index + 14'h0001;
			next_rollover = (next_index[12:3] & list_mask) == 10'h000
				&& microframe_index[2:0] == 3'h7;
		end
		next_list = next_index[12:`FIC_LIST_LSB] & list_mask;
	end

	// Configure flag and port owners
	always_comb begin
		next_cfg = configured_bit;
		if (cfg_wr) begin
			next_cfg = bus_req.wdata[`FIC_CFG_BIT];
		end
		for (int i = 0; i < `FIC_NUM_PORTS; i++) begin
			next_owner[i] = port_owner[i];
			if (port_owner_wr[i]) begin
				next_owner[i] = port_owner_wdata[i];
			end
			if (!next_cfg) begin
				next_owner[i] = 1'b1;
			end else if (!configured_bit) begin
				next_owner[i] = 1'b0;
			end
		end
	end

	// Read data
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (bus_req.addr)
			`FIC_OFF_INTR_EN: next_rdata = 32'h0000_0000;
			`FIC_OFF_UF_INDEX: next_rdata = {18'h00000, microframe_index};
			`FIC_OFF_CONFIG: next_rdata = {31'h00000000, configured_bit};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			microframe_index <= `FIC_UF_INDEX_RST;
			configured_bit <= `FIC_CFG_RST;
			port_owner <= {`FIC_NUM_PORTS{1'b1}};
			frame <= '0;
			frame_list_rollover <= 1'b0;
			schedule_run <= 1'b0;
			bus_rdata <= 32'h0000_0000;
			bus_rvalid <= 1'b0;
		end else begin
			microframe_index <= next_index;
			configured_bit <= next_cfg;
			port_owner <= next_owner;
			frame.frame_number <= next_index;
			frame.list_index <= next_list;
			frame.rollover <= next_rollover;
			frame_list_rollover <= next_rollover;
			schedule_run <= run_stop;
			bus_rdata <= bus_req.rd ? next_rdata : 32'h0000_0000;
			bus_rvalid <= bus_req.rd;
		end
	end

	property p_intr_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		bus_req.rd && bus_req.addr == `FIC_OFF_INTR_EN |=> bus_rdata == 0;
	endproperty
	a_intr_zero: assert property (p_intr_zero)
		else $error("interrupt enable read nonzero");

	property p_index_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!tick && !idx_wr |=> $stable(microframe_index);
	endproperty
	a_index_hold: assert property (p_index_hold)
		else $error("frame index moved without tick");

	property p_index_step;
		@(posedge ref_clk) disable iff (sys_rst)
		tick && !idx_wr |=> microframe_index == 14'($past(microframe_index) + 1);
	endproperty
	a_index_step: assert property (p_index_step)
		else $error("frame index bad step");

	property p_list;
		@(posedge ref_clk) disable iff (sys_rst)
		##1 frame.list_index == (microframe_index[12:3] & $past(list_mask));
	endproperty
	a_list: assert property (p_list)
		else $error("list index mismatch");

	property p_sof;
		@(posedge ref_clk) disable iff (sys_rst)
		##1 frame.frame_number == microframe_index;
	endproperty
	a_sof: assert property (p_sof)
		else $error("frame number mismatch");

	property p_write;
		@(posedge ref_clk) disable iff (sys_rst)
		idx_wr |=> microframe_index == $past(bus_req.wdata[13:0]);
	endproperty
	a_write: assert property (p_write)
		else $error("frame index write lost");

	property p_cfg_read;
		@(posedge ref_clk) disable iff (sys_rst)
		bus_req.rd && bus_req.addr == `FIC_OFF_CONFIG
		|=> bus_rdata == {31'h0, $past(configured_bit)};
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("configure flag read wrong");

	property p_owner;
		@(posedge ref_clk) disable iff (sys_rst)
		!configured_bit |-> port_owner == {`FIC_NUM_PORTS{1'b1}};
	endproperty
	a_owner: assert property (p_owner)
		else $error("port owner not held while unconfigured");

	property p_rise;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(configured_bit) |-> port_owner == '0;
	endproperty
	a_rise: assert property (p_rise)
		else $error("port owner not cleared on configure");

	property p_roll;
		@(posedge ref_clk) disable iff (sys_rst)
		frame_list_rollover |-> (frame.list_index == 10'h000);
	endproperty
	a_roll: assert property (p_roll)
		else $error("rollover without wrap");

	c_tick: cover property (@(posedge ref_clk) tick);
	c_roll: cover property (@(posedge ref_clk) frame_list_rollover);
	c_cfg: cover property (@(posedge ref_clk) $rose(configured_bit));

endmodule : fic_regs

// *** verification/fic_host_model.sv ***
/*
 Host software model issuing word register cycles.
 Assumes the one-cycle strobe port of fic_regs.
*/
`timescale 1ns/1ps
module fic_host_model
	import fic_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Register port
	output fic_bus_req_s bus_req,
	output logic [3:0] bus_be,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_rvalid
);
	initial begin
		bus_req = '0;
		bus_be = 4'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge ref_clk);
		#1;
		bus_req = '{1'b1, 1'b0, a, d};
		bus_be = be;
		@(posedge ref_clk);
		#1;
		bus_req = '{1'b0, 1'b0, ~a, ~d};
		bus_be = ~be;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		#1;
		bus_req = '{1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		#1;
		bus_req.rd = 1'b0;
		d = bus_rvalid ? bus_rdata : 32'hdead_beef;
	endtask : rd
endmodule : fic_host_model

// *** verification/tb_fic_regs.sv ***
/*
 Self-checking bench for the frame index and configure flag slice.
 Assumes fic_host_model plays the software side.
*/
`timescale 1ns/1ps
module tb_fic_regs;
	import fic_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] be;
		logic [31:0] q;
	} fic_row_s;
	logic ref_clk, sys_rst, run_stop, bus_rvalid, ro;
	logic frame_list_rollover, schedule_run, configured_bit;
	logic [1:0] frame_list_size;
	logic [2:0] own_wr, own_wd, port_owner;
	logic [3:0] bus_be;
	logic [31:0] bus_rdata, rd_val;
	logic [9:0] lexp[4] = '{10'h3ff, 10'h1ff, 10'h0ff, 10'h3ff};
	fic_bus_req_s bus_req;
	fic_frame_s frame;
	int error_cnt, checks_done, c;
	fic_row_s rows[5] = '{'{8'h2c, 32'h0000_3fff, 4'hf, 32'h3fff},
		'{8'h2c, 32'h1234, 4'h3, 32'h3fff}, '{8'h28, 32'h1, 4'hf, 32'h0},
		'{8'h44, 32'hffff, 4'hf, 32'h0}, '{8'h60, 32'h1, 4'hf, 32'h1}};
	fic_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_be(bus_be), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.run_stop(run_stop), .frame_list_size(frame_list_size),
		.port_owner_wr(own_wr), .port_owner_wdata(own_wd), .frame(frame),
		.frame_list_rollover(frame_list_rollover),
		.schedule_run(schedule_run), .configured_bit(configured_bit),
		.port_owner(port_owner));
	fic_host_model host (.ref_clk(ref_clk), .bus_req(bus_req),
		.bus_be(bus_be), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
	task automatic cmp(input string s, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask : cmp
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// Waits for the frame number to move, bounded
	task automatic wait_tick();
		fic_index_t f;
		f = frame.frame_number;
		c = 0;
		do begin
			@(posedge ref_clk);
			#1;
			c++;
		end while (frame.frame_number === f && c < 1300);
		ro = frame_list_rollover;
		if (c >= 1300) begin
			error_cnt++;
			end_sim();
		end
	endtask : wait_tick
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		sys_rst = 1'b1;
		run_stop = 1'b0;
		frame_list_size = 2'h0;
		own_wr = 3'h0;
		own_wd = 3'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		cmp("owner", 3'b111, port_owner);
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d, rows[i].be);
			host.rd(rows[i].a, rd_val);
			cmp("read", rows[i].q, rd_val);
		end
		cmp("fnum", 14'h3fff, frame.frame_number);
		cmp("cfg", 1'b1, configured_bit);
		cmp("owner", 3'b000, port_owner);
		$display("register rows done");
		own_wr = 3'h7;
		own_wd = 3'h5;
		@(posedge ref_clk);
		#1;
		own_wr = 3'h0;
		cmp("owner", 3'h5, port_owner);
		host.wr(8'h60, 32'h0, 4'hf);
		cmp("owner", 3'h7, port_owner);
		host.wr(8'h60, 32'h1, 4'hf);
		cmp("owner", 3'h0, port_owner);
		$display("owner test done");
		run_stop = 1'b1;
		wait_tick();
		cmp("wrap", 14'h0, frame.frame_number);
		cmp("list", 10'h0, frame.list_index);
		cmp("roll", 1'b1, ro);
		cmp("froll", 1'b1, frame.rollover);
		cmp("sched", 1'b1, schedule_run);
		wait_tick();
		cmp("period", 1250, c);
		cmp("fnum", 14'h1, frame.frame_number);
		cmp("roll", 1'b0, ro);
		run_stop = 1'b0;
		host.wr(8'h2c, 32'h1ff8, 4'hf);
		for (int k = 0; k < 4; k++) begin
			frame_list_size = k[1:0];
			repeat (2) @(posedge ref_clk);
			#1;
			cmp("size", lexp[k], frame.list_index);
		end
		$display("tick test done");
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		cmp("fnum", 14'h0, frame.frame_number);
		cmp("cfg", 1'b0, configured_bit);
		cmp("sched", 1'b0, schedule_run);
		cmp("owner", 3'h7, port_owner);
		$display("reset test done");
		end_sim();
	end
endmodule : tb_fic_regs
